/* File: inc/lhfm_pkg.sv */
// Constants, fault bit layout and state encodings of the laser head fault monitor.
// Assumes temperatures arrive as signed 16-bit codes in units of 0.1 degC.
package lhfm_pkg;

  // Fault word width and hex answer geometry
  localparam int unsigned FAULT_W = 32;
  localparam int unsigned DIGIT_W = 4;
  localparam int unsigned DIGITS = FAULT_W / DIGIT_W;
  localparam logic [2:0] LAST_DIGIT = 3'h7;

  // Fault bit values in the fault words
  localparam logic [31:0] F_FILTER = 32'h0000_0001;
  localparam logic [31:0] F_DOUBLER = 32'h0000_0002;
  localparam logic [31:0] F_TRIPLER = 32'h0000_0004;
  localparam logic [31:0] F_ETALON = 32'h0000_0008;
  localparam logic [31:0] F_RESONATOR = 32'h0000_0010;
  localparam logic [31:0] F_HEATSINK = 32'h0000_0100;
  localparam logic [31:0] F_INTERNAL = 32'h0000_0200;
  localparam logic [31:0] F_DIODE_DRV = 32'h0001_0000;
  localparam logic [31:0] F_SHUTTER = 32'h0002_0000;
  localparam logic [31:0] F_HEAD_MEM = 32'h0100_0000;
  localparam logic [31:0] F_BOARD_MEM = 32'h0200_0000;
  localparam logic [31:0] F_WARMUP_TO = 32'h0200_0000;
  localparam logic [31:0] FAULT_RESET = 32'h0000_0000;

  // Temperature thresholds in 0.1 degC
  localparam logic signed [15:0] RESONATOR_LIMIT = 16'sh010E; // 27.0 degC
  localparam logic signed [15:0] HEATSINK_LIMIT = 16'sh0258; // 60 degC
  localparam logic signed [15:0] BASEPLATE_HOT = 16'sh0258; // 60 degC, above trips
  localparam logic signed [15:0] BASEPLATE_COOL = 16'sh012C; // 30 degC, below clears

  // Warm-up deadline
  localparam longint unsigned CLK_HZ = 64'd10_000_000;
  localparam longint unsigned WARMUP_S = 64'd120; // two minutes
  localparam longint unsigned WARMUP_CYCLES_DEF = CLK_HZ * WARMUP_S;

  // ASCII codes for hex digits
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_A_MINUS_10 = 8'h37;
  localparam logic [3:0] NIBBLE_NINE = 4'h9;

  // Virtual key clearing sequence states
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_OFF1 = 3'b010,
    KEY_ON = 3'b100
  } lhfm_key_e;

endpackage

/* File: rtl/lhfm_monitor.sv */
// Laser head fault monitor: live and latched fault words, hex answers,
// heat-sink and baseplate latches, key clearing sequence and start-up recall.
// Assumes a command parser that decodes host text into the strobes below.
`timescale 1ns/100ps

module lhfm_monitor
  import lhfm_pkg::*;
#(
  parameter longint unsigned WARMUP_CYCLES = WARMUP_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Temperature codes, 0.1 degC
  input wire logic signed [15:0] resonator_temp_i,
  input wire logic signed [15:0] heatsink_temp_i,
  input wire logic signed [15:0] baseplate_temp_i,
  // Fault condition levels
  input wire logic [3:0] crystal_out_of_range_i,
  input wire logic internal_temp_bad_i,
  input wire logic diode_driver_fault_i,
  input wire logic shutter_fault_i,
  input wire logic head_mem_fault_i,
  input wire logic board_mem_fault_i,
  input wire logic baseplate_sensor_open_i,
  input wire logic baseplate_sensor_short_i,
  // Host command strobes
  input wire logic restart_cmd_i,
  input wire logic virtual_key_command_i,
  input wire logic virtual_key_alt_command_i,
  input wire logic virtual_key_value_i,
  input wire logic power_write_i,
  input wire logic [15:0] power_value_i,
  input wire logic modulation_write_i,
  input wire logic modulation_value_i,
  // Non-volatile start-up settings
  input wire logic [15:0] startup_power_i,
  input wire logic startup_modulation_store_i,
  input wire logic auto_start_setting_i,
  // Physical key
  input wire logic physical_key_i,
  // Fault queries and hex answer stream
  input wire logic live_fault_query_i,
  input wire logic latched_fault_query_i,
  output logic query_ready_o,
  output logic answer_valid_o,
  input wire logic answer_ready_i,
  output logic [7:0] answer_char_o,
  output logic answer_last_o,
  // Status outputs
  output logic [31:0] live_fault_word_o,
  output logic [31:0] latched_fault_word_o,
  output logic baseplate_fault_o,
  output logic composite_key_query_o,
  output logic warmup_done_o,
  output logic [15:0] power_setpoint_o,
  output logic modulation_state_o,
  output logic emission_enable_o
);

  // Nibble to upper-case ASCII hex digit
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    if (nib > NIBBLE_NINE) begin
      hex_char = ASCII_A_MINUS_10 + {4'h0, nib};
    end else begin
      hex_char = ASCII_ZERO + {4'h0, nib};
    end
  endfunction

  // Fault latches and warm-up state
  logic heatsink_q, heatsink_d;       // Heat-sink latch
  logic bp_fault_q, bp_fault_d;       // Baseplate latch
  logic bp_sensor_q, bp_sensor_d;     // Permanent sensor fault
  logic warm_done_q, warm_done_d;     // Crystals reached temperature
  logic timeout_q, timeout_d;         // Warm-up deadline missed
  logic [31:0] warm_cnt_q, warm_cnt_d; // Cycles since power on, held at warm-up end or deadline
  logic [31:0] latched_q, latched_d;  // Latched fault word
  logic [31:0] live_word;             // Live fault word
  logic warm_end;                     // Warm-up completes this cycle
  logic latch_on;                     // Latching active

  // Key sequence, host settings and start-up recall
  lhfm_key_e key_q, key_d;
  logic vkey_q, vkey_d;               // Virtual key state
  logic key_cmd;                      // Either virtual key command
  logic key_clear;                    // Off-on-off sequence completed
  logic init_q, init_d;               // Start-up values loaded
  logic [15:0] power_q, power_d;
  logic mod_q, mod_d;

  // Answer serializer
  logic busy_q, busy_d;
  logic [31:0] shift_q, shift_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] char_q, char_d;

  // Live fault word assembly; bits combine by OR
  always_comb begin
    live_word = FAULT_RESET;
    if (crystal_out_of_range_i[0]) live_word = live_word | F_FILTER;
    if (crystal_out_of_range_i[1]) live_word = live_word | F_DOUBLER;
    if (crystal_out_of_range_i[2]) live_word = live_word | F_TRIPLER;
    if (crystal_out_of_range_i[3]) live_word = live_word | F_ETALON;
    if (resonator_temp_i >= RESONATOR_LIMIT) live_word = live_word | F_RESONATOR;
    if (heatsink_q) live_word = live_word | F_HEATSINK;
    if (internal_temp_bad_i) live_word = live_word | F_INTERNAL;
    if (diode_driver_fault_i) live_word = live_word | F_DIODE_DRV;
    if (shutter_fault_i) live_word = live_word | F_SHUTTER;
    if (head_mem_fault_i) live_word = live_word | F_HEAD_MEM;
    if (board_mem_fault_i) live_word = live_word | F_BOARD_MEM;
    if (timeout_q) live_word = live_word | F_WARMUP_TO;
  end

  // Fault latches, warm-up timer and latched word next state
  always_comb begin
    // Heat-sink latch: only restart or power-on reset releases it
    heatsink_d = heatsink_q;
    if (restart_cmd_i) begin
      heatsink_d = 1'b0;
    end
    if (heatsink_temp_i >= HEATSINK_LIMIT) begin
      heatsink_d = 1'b1;
    end
    // Sensor faults stick until power is removed
    bp_sensor_d = bp_sensor_q | baseplate_sensor_open_i | baseplate_sensor_short_i;
    // Baseplate latch: trip wins over a clear in the same cycle
    bp_fault_d = bp_fault_q;
    if (key_clear && (baseplate_temp_i < BASEPLATE_COOL) && !bp_sensor_q) begin
      bp_fault_d = 1'b0;
    end
    if ((baseplate_temp_i > BASEPLATE_HOT) || bp_sensor_d) begin
      bp_fault_d = 1'b1;
    end
    // Warm-up: done once all crystals are in range
    warm_end = !warm_done_q && (crystal_out_of_range_i == 4'h0);
    warm_done_d = warm_done_q | warm_end;
    warm_cnt_d = warm_cnt_q;
    timeout_d = timeout_q;
    if (!warm_done_q) begin
      if (warm_cnt_q >= WARMUP_CYCLES[31:0] - 32'h1) begin
        // A missed deadline stays recorded until power-on reset
        timeout_d = timeout_q | !warm_end;
      end else begin
        warm_cnt_d = warm_cnt_q + 32'h1;
      end
    end
    // Latched word: starts fresh at warm-up end, also runs after a timeout
    latch_on = warm_done_q | timeout_q;
    if (warm_end) begin
      latched_d = FAULT_RESET;
    end else if (latch_on) begin
      latched_d = latched_q | live_word;
    end else begin
      latched_d = latched_q;
    end
  end

  // Virtual key, clearing sequence and setting recall next state
  always_comb begin
    key_cmd = virtual_key_command_i | virtual_key_alt_command_i;
    vkey_d = key_cmd ? virtual_key_value_i : vkey_q;
    key_d = key_q;
    key_clear = 1'b0;
    if (key_cmd) begin
      case (key_q)
        KEY_IDLE: begin
          key_d = virtual_key_value_i ? KEY_IDLE : KEY_OFF1;
        end
        KEY_OFF1: begin
          key_d = virtual_key_value_i ? KEY_ON : KEY_OFF1;
        end
        KEY_ON: begin
          // Final off completes the sequence
          key_clear = !virtual_key_value_i;
          key_d = virtual_key_value_i ? KEY_IDLE : KEY_OFF1;
        end
        default: begin
          key_d = KEY_IDLE;
        end
      endcase
    end
    // Start-up recall in the first cycle after reset, then host writes
    init_d = 1'b1;
    power_d = power_q;
    mod_d = mod_q;
    if (!init_q) begin
      power_d = startup_power_i;
      mod_d = startup_modulation_store_i | auto_start_setting_i;
    end else begin
      if (power_write_i) power_d = power_value_i;
      if (modulation_write_i) mod_d = modulation_value_i;
    end
  end

  // Hex answer serializer next state, most significant digit first
  always_comb begin
    busy_d = busy_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    char_d = char_q;
    if (!busy_q) begin
      // Word captured at the moment the query is served
      if (live_fault_query_i) begin
        busy_d = 1'b1;
        char_d = hex_char(live_word[31:28]);
        shift_d = {live_word[27:0], 4'h0};
        cnt_d = LAST_DIGIT;
      end else if (latched_fault_query_i) begin
        busy_d = 1'b1;
        char_d = hex_char(latched_q[31:28]);
        shift_d = {latched_q[27:0], 4'h0};
        cnt_d = LAST_DIGIT;
      end
    end else if (answer_ready_i) begin
      if (cnt_q == 3'h0) begin
        busy_d = 1'b0;
      end else begin
        char_d = hex_char(shift_q[31:28]);
        shift_d = {shift_q[27:0], 4'h0};
        cnt_d = cnt_q - 3'h1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      heatsink_q <= 1'b0;
      bp_fault_q <= 1'b0;
      bp_sensor_q <= 1'b0;
      warm_done_q <= 1'b0;
      timeout_q <= 1'b0;
      warm_cnt_q <= 32'h0;
      latched_q <= FAULT_RESET;
      key_q <= KEY_IDLE;
      vkey_q <= 1'b0;
      init_q <= 1'b0;
      power_q <= 16'h0;
      mod_q <= 1'b0;
      busy_q <= 1'b0;
      shift_q <= 32'h0;
      cnt_q <= 3'h0;
      char_q <= 8'h0;
    end else begin
      heatsink_q <= heatsink_d;
      bp_fault_q <= bp_fault_d;
      bp_sensor_q <= bp_sensor_d;
      warm_done_q <= warm_done_d;
      timeout_q <= timeout_d;
      warm_cnt_q <= warm_cnt_d;
      latched_q <= latched_d;
      key_q <= key_d;
      vkey_q <= vkey_d;
      init_q <= init_d;
      power_q <= power_d;
      mod_q <= mod_d;
      busy_q <= busy_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      char_q <= char_d;
    end
  end

  // Outputs
  assign query_ready_o = !busy_q;
  assign answer_valid_o = busy_q;
  assign answer_char_o = char_q;
  assign answer_last_o = busy_q && (cnt_q == 3'h0);
  assign live_fault_word_o = live_word;
  assign latched_fault_word_o = latched_q;
  assign baseplate_fault_o = bp_fault_q;
  assign composite_key_query_o = physical_key_i & vkey_q;
  assign warmup_done_o = warm_done_q;
  assign power_setpoint_o = power_q;
  assign modulation_state_o = mod_q;
  // Every fault in the live word inhibits; baseplate latch blocks turn-on
  assign emission_enable_o = physical_key_i & vkey_q & mod_q & init_q &
                             (live_word == FAULT_RESET) & !bp_fault_q;

endmodule // lhfm_monitor

/* File: verif/lhfm_chk_monitor.sv */
// Port checker for the fault monitor.
// Assumes binding to lhfm_monitor; watches its ports only.
`timescale 1ns/100ps
module lhfm_chk
  import lhfm_pkg::*;
#(parameter longint unsigned WARMUP_CYCLES = 50) (
  // Clock, reset and sensed inputs
  input wire logic clk_i, reset_n_i, internal_temp_bad_i, diode_driver_fault_i,
  input wire logic signed [15:0] resonator_temp_i, heatsink_temp_i, baseplate_temp_i,
  input wire logic baseplate_sensor_open_i, baseplate_sensor_short_i, restart_cmd_i,
  input wire logic physical_key_i, live_fault_query_i, latched_fault_query_i, answer_ready_i,
  // Watched outputs
  input wire logic query_ready_o, answer_valid_o, answer_last_o, baseplate_fault_o,
  input wire logic composite_key_query_o, warmup_done_o, emission_enable_o,
  input wire logic [7:0] answer_char_o,
  input wire logic [31:0] live_fault_word_o, latched_fault_word_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Fault bits follow their sources
  drv_bit_a: assert property (live_fault_word_o[16] == diode_driver_fault_i)
    else $error("driver fault bit wrong");
  int_bit_a: assert property (live_fault_word_o[9] == internal_temp_bad_i)
    else $error("internal temp bit wrong");
  reson_bit_a: assert property (live_fault_word_o[4] == (resonator_temp_i >= 16'sd270))
    else $error("resonator bit wrong");
  hs_set_a: assert property (heatsink_temp_i >= 16'sd600 |-> ##[0:1] live_fault_word_o[8])
    else $error("heat sink bit not set");
  hs_hold_a: assert property (live_fault_word_o[8] && !restart_cmd_i |=> live_fault_word_o[8])
    else $error("heat sink latch lost");
  // Answer stream handshake
  query_take_a: assert property (
    query_ready_o && (live_fault_query_i || latched_fault_query_i)
    |=> answer_valid_o && !query_ready_o && !answer_last_o)
    else $error("query not taken");
  char_hold_a: assert property (answer_valid_o && !answer_ready_i
    |=> answer_valid_o && $stable(answer_char_o))
    else $error("answer char not held");
  // Characters accepted since the query was taken
  logic [3:0] acc_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_q <= 4'h0;
    end else if (query_ready_o) begin
      acc_q <= 4'h0;
    end else if (answer_valid_o && answer_ready_i) begin
      acc_q <= acc_q + 4'h1;
    end
  end
  last_mark_a: assert property (answer_valid_o |-> answer_last_o == (acc_q == 4'h7))
    else $error("last mark not on eighth char");
  // Key, emission and baseplate latch
  key_and_a: assert property (composite_key_query_o |-> physical_key_i)
    else $error("key without physical key");
  emit_block_a: assert property (live_fault_word_o != 0 || baseplate_fault_o
    |-> !emission_enable_o)
    else $error("emission during fault");
  bp_trip_a: assert property (baseplate_temp_i > 16'sd600 || baseplate_sensor_open_i
    || baseplate_sensor_short_i |=> baseplate_fault_o)
    else $error("baseplate fault not raised");
  bp_keep_a: assert property (baseplate_fault_o && baseplate_temp_i >= 16'sd300
    |=> baseplate_fault_o)
    else $error("baseplate cleared while warm");
  latch_keep_a: assert property (warmup_done_o && live_fault_word_o[16]
    |=> latched_fault_word_o[16])
    else $error("latched bit missing");
  cover property (answer_valid_o && answer_ready_i && answer_last_o);
  cover property ($fell(baseplate_fault_o));
  cover property (emission_enable_o);
endmodule // lhfm_chk

/* File: verif/lhfm_host.sv */
// Host model: fault queries, virtual key and restart commands.
// Assumes the bench clock; drives on falling edges.
`timescale 1ns/100ps
module lhfm_host (
  input wire logic clk_i, query_ready_o, answer_valid_o, answer_last_o,
  input wire logic [7:0] answer_char_o,
  output logic live_fault_query_i, latched_fault_query_i, answer_ready_i,
  output logic virtual_key_command_i, virtual_key_alt_command_i, virtual_key_value_i,
  output logic restart_cmd_i
);
  integer seed = 32'h1075;
  initial begin
    {live_fault_query_i, latched_fault_query_i, answer_ready_i, restart_cmd_i} = '0;
    {virtual_key_command_i, virtual_key_alt_command_i, virtual_key_value_i} = '0;
  end
  // Query one word, stalling the stream at random, gather eight digits
  task automatic ask(input logic lat, input integer stall, output logic [31:0] w);
    integer n, g;
    n = 0;
    g = 0;
    w = '0;
    @(negedge clk_i);
    live_fault_query_i = !lat;
    latched_fault_query_i = lat;
    while (n < 8 && g < 400) begin
      @(negedge clk_i);
      {live_fault_query_i, latched_fault_query_i} = '0;
      answer_ready_i = (($random(seed) & 3) >= stall);
      if (answer_valid_o && answer_ready_i) begin
        w = {w[27:0], answer_char_o[6] ? answer_char_o[3:0] + 4'h9 : answer_char_o[3:0]};
        n++;
      end
      g++;
    end
    @(negedge clk_i) answer_ready_i = 0;
  endtask
  // One virtual key write through either command
  task automatic key(input logic v, input logic alt);
    @(negedge clk_i);
    virtual_key_value_i = v;
    {virtual_key_command_i, virtual_key_alt_command_i} = {!alt, alt};
    @(negedge clk_i);
    {virtual_key_command_i, virtual_key_alt_command_i} = '0;
    virtual_key_value_i = !v;
  endtask
  // System restart pulse
  task automatic restart;
    @(negedge clk_i) restart_cmd_i = 1;
    @(negedge clk_i) restart_cmd_i = 0;
  endtask
endmodule // lhfm_host

/* File: verif/lhfm_monitor_bench.sv */
// Self-checking bench of the fault monitor against an integer model.
// Assumes lhfm_pkg, lhfm_host and lhfm_chk are compiled first.
`timescale 1ns/100ps
module lhfm_monitor_bench;
  import lhfm_pkg::*;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
  logic clk_i, reset_n_i, internal_temp_bad_i, diode_driver_fault_i, shutter_fault_i;
  logic signed [15:0] resonator_temp_i, heatsink_temp_i, baseplate_temp_i;
  logic [3:0] crystal_out_of_range_i;
  logic head_mem_fault_i, board_mem_fault_i, baseplate_sensor_open_i, baseplate_sensor_short_i;
  logic restart_cmd_i, virtual_key_command_i, virtual_key_alt_command_i, virtual_key_value_i;
  logic power_write_i, modulation_write_i, modulation_value_i, startup_modulation_store_i;
  logic auto_start_setting_i, physical_key_i, live_fault_query_i, latched_fault_query_i;
  logic answer_ready_i, query_ready_o, answer_valid_o, answer_last_o, emission_enable_o;
  logic baseplate_fault_o, composite_key_query_o, warmup_done_o, modulation_state_o;
  logic [15:0] power_value_i, startup_power_i, power_setpoint_o;
  logic [7:0] answer_char_o;
  logic [31:0] live_fault_word_o, latched_fault_word_o, w, lw;
  integer fails = 0, n_checks = 0, seed = 32'h1075, k, hs;
  lhfm_monitor #(.WARMUP_CYCLES(50)) i_lhfm_monitor (.*);
  lhfm_host i_lhfm_host (.*);
  initial begin clk_i = 0; forever #50 clk_i = ~clk_i; end
  // Expected live word from the present inputs
  function automatic logic [31:0] model(input logic to);
    return {28'h0, crystal_out_of_range_i} | (resonator_temp_i >= 270 ? F_RESONATOR : 0)
      | (hs ? F_HEATSINK : 0) | (internal_temp_bad_i ? F_INTERNAL : 0)
      | (diode_driver_fault_i ? F_DIODE_DRV : 0) | (shutter_fault_i ? F_SHUTTER : 0)
      | (head_mem_fault_i ? F_HEAD_MEM : 0) | (board_mem_fault_i || to ? F_WARMUP_TO : 0);
  endfunction
  task automatic tick(input integer n); repeat (n) @(negedge clk_i); endtask
  task automatic do_reset; reset_n_i = 0; hs = 0; tick(3); reset_n_i = 1; tick(1); endtask
  task automatic ask_chk(input logic l, input logic [31:0] e);
    i_lhfm_host.ask(l, $random(seed) & 3, w);
    `CHK(w, e)
  endtask
  task automatic finish_test;
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin #1ms; fails++; finish_test; end
  initial begin
    {resonator_temp_i, heatsink_temp_i, baseplate_temp_i, internal_temp_bad_i} = '0;
    {diode_driver_fault_i, shutter_fault_i, head_mem_fault_i, board_mem_fault_i} = '0;
    {baseplate_sensor_open_i, baseplate_sensor_short_i, power_write_i, power_value_i} = '0;
    {modulation_write_i, modulation_value_i, startup_power_i, physical_key_i} = '0;
    {startup_modulation_store_i, auto_start_setting_i, reset_n_i} = '0;
    crystal_out_of_range_i = 4'hF;
    // Start-up recall; live writes are not kept over a reset
    for (k = 0; k < 3; k++) begin
      {startup_modulation_store_i, auto_start_setting_i} = {k == 1, k == 2};
      startup_power_i = 16'($random(seed));
      do_reset;
      `CHK(power_setpoint_o, startup_power_i)
      `CHK(modulation_state_o, k > 0)
      `CHK(live_fault_word_o, model(0))
      {power_value_i, power_write_i} = {16'($random(seed)), 1'b1};
      {modulation_value_i, modulation_write_i} = {k == 0, 1'b1};
      tick(1);
      {power_write_i, modulation_write_i} = '0;
      `CHK(power_setpoint_o, power_value_i)
      `CHK(modulation_state_o, k == 0)
    end
    // Crystals settle late: timeout, then warm-up restarts the latch
    tick(55);
    `CHK(warmup_done_o, 1'b0)
    ask_chk(0, model(1));
    crystal_out_of_range_i = 0;
    tick(2);
    `CHK(warmup_done_o, 1'b1)
    ask_chk(1, F_WARMUP_TO);
    // Random fault mixes, live and latched answers
    lw = F_WARMUP_TO;
    for (k = 0; k < 8; k++) begin
      {crystal_out_of_range_i, internal_temp_bad_i, diode_driver_fault_i, shutter_fault_i,
       head_mem_fault_i, board_mem_fault_i} = 9'($random(seed));
      resonator_temp_i = 16'sd268 + 16'($random(seed) & 3);
      heatsink_temp_i = 16'sd598 + 16'($random(seed) & 3);
      if (heatsink_temp_i >= 600) hs = 1;
      tick(2);
      `CHK(live_fault_word_o, model(1))
      lw = lw | model(1);
      ask_chk(0, model(1));
      ask_chk(1, lw);
      if (k[0]) begin i_lhfm_host.restart; if (heatsink_temp_i < 600) hs = 0; end
    end
    // Clean start; baseplate trips, refused clear, clear, sensor fault
    {crystal_out_of_range_i, internal_temp_bad_i, diode_driver_fault_i, shutter_fault_i} = '0;
    {head_mem_fault_i, board_mem_fault_i, resonator_temp_i, heatsink_temp_i} = '0;
    do_reset;
    physical_key_i = 1;
    i_lhfm_host.key(1, 0);
    tick(1);
    `CHK(composite_key_query_o, 1'b1)
    `CHK(emission_enable_o, 1'b1)
    diode_driver_fault_i = 1;
    tick(1);
    `CHK(emission_enable_o, 1'b0)
    diode_driver_fault_i = 0;
    for (k = 0; k < 3; k++) begin
      baseplate_sensor_open_i = k == 2;
      baseplate_temp_i = k == 2 ? 16'sd250 : 16'sd601;
      tick(2);
      `CHK(emission_enable_o, 1'b0)
      baseplate_temp_i = k == 0 ? 16'sd300 : 16'sd299;
      i_lhfm_host.key(0, 0);
      i_lhfm_host.key(1, 0);
      i_lhfm_host.key(0, 1);
      tick(1);
      `CHK(baseplate_fault_o, k != 1)
    end
    physical_key_i = 0;
    i_lhfm_host.key(1, 1);
    tick(1);
    `CHK(composite_key_query_o, 1'b0)
    finish_test;
  end
endmodule // lhfm_monitor_bench
bind lhfm_monitor lhfm_chk #(.WARMUP_CYCLES(WARMUP_CYCLES)) i_lhfm_chk (.*);
